// [design/cpu_state_pkg.sv]
// Purpose: Shared constants and types for the processing-state sequencer.
// Assumes: 25 MHz core clock; word-aligned vector table and stack.
// Notes: Register offsets are byte addresses on the plain register port.
// Functional notes
// - CPU always in one of five states.
// - Reset pin low holds reset; NMI picks kind.
// - Power-on reset initialises everything.
// - Manual reset spares bus and pin controllers.
// - Reset exit fetches PC, SP, then runs.
// - Exceptions push SR, PC, then fetch vector.
// - SLEEP with standby bit clear enters sleep.
// - Sleep exits on interrupt, DMA error, reset.
// - SLEEP with standby bit set enters standby.
// - Standby peripheral and pin treatment is per-module.
// - Standby exits on NMI after oscillator settling.
// - Bus release grants bus, no own accesses.
// - Mode 000 gives 8-bit, 001 16-bit area 0.
// - Mode 010 on-chip ROM, 111 PROM mode.
// - Reset vectors at fixed addresses; clear base, set mask.
// - Interrupt acceptance writes its level into mask.
package cpu_state_pkg;
  // Register port layout.
  localparam int ADDR_W = 8;
  localparam logic [7:0] STANDBY_CTRL_ADDR = 8'h00;
  localparam logic [7:0] VECTOR_BASE_ADDR = 8'h04;
  localparam logic [7:0] STATUS_ADDR = 8'h08;
  localparam int STANDBY_BIT_POS = 0;
  localparam int STAT_STATE_LSB = 0;
  localparam int STAT_MASK_LSB = 4;
  localparam int STAT_MODE_LSB = 8;
  localparam int STAT_POR_BIT = 12;
  localparam int STAT_STBY_BIT = 13;
  // Reset values and vector table addresses.
  localparam logic [31:0] VBR_RESET = 32'h0000_0000;
  localparam logic [3:0] MASK_RESET = 4'hF;
  localparam logic [31:0] POR_PC_ADDR = 32'h0000_0000;
  localparam logic [31:0] POR_SP_ADDR = 32'h0000_0004;
  localparam logic [31:0] MAN_PC_ADDR = 32'h0000_0008;
  localparam logic [31:0] MAN_SP_ADDR = 32'h0000_000C;
  localparam logic [31:0] STACK_WORD = 32'h0000_0004;
  localparam logic [7:0] DMA_ADDR_ERR_VEC = 8'h0A;
  localparam logic [7:0] NMI_VEC = 8'h0B;
  localparam logic [3:0] NMI_LEVEL = 4'hF;
  // Operating mode pin codes.
  localparam logic [2:0] MODE_AREA0_8BIT = 3'h0;
  localparam logic [2:0] MODE_AREA0_16BIT = 3'h1;
  localparam logic [2:0] MODE_AREA0_ROM = 3'h2;
  localparam logic [2:0] MODE_PROM = 3'h7;
  // Timing: oscillator settling, a least time, so it rounds up.
  localparam int CLK_PERIOD_NS = 40;
  localparam int OSC_STAB_NS = 10000000;
  localparam int OSC_STAB_CYCLES = (OSC_STAB_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    ST_RESET = 3'b000,
    ST_EXC = 3'b001,
    ST_BUSREL = 3'b010,
    ST_EXEC = 3'b011,
    ST_PDOWN = 3'b100
  } cpu_state_t;
  typedef enum logic [2:0] {
    X_PUSH_SR = 3'b000,
    X_PUSH_PC = 3'b001,
    X_RD_VEC = 3'b010,
    X_RD_PC = 3'b011,
    X_RD_SP = 3'b100,
    X_LOAD = 3'b101
  } exc_step_t;
endpackage : cpu_state_pkg

// [design/pin_sync_if.sv]
// Purpose: Carries raw pin levels to the synchroniser and clean levels back.
// Assumes: All raw levels are asynchronous to the core clock.
// Notes: Width is set by the instantiating module.
`timescale 1ns/1ns
interface pin_sync_if #(parameter int W = 1);
  logic [W-1:0] raw;
  logic [W-1:0] clean;
  modport sync_end (input raw, output clean);
  modport user_end (output raw, input clean);
endinterface : pin_sync_if

// [design/pin_sync.sv]
// Purpose: Two-flop synchroniser for a group of pin levels.
// Assumes: Pins are levels, not pulses shorter than two clocks.
// Notes: The first stage feeds only the second stage.
`timescale 1ns/1ns
module pin_sync #(
  parameter int W = 1
) (
  input wire logic i_clk,
  input wire logic i_rstn,
  pin_sync_if.sync_end p
);
  logic [W-1:0] meta;
  logic [W-1:0] stable;

  if (W < 1)
  begin : g_bad_width
    $error("pin_sync needs at least one bit");
  end

  // Two stages; the reset value is a constant, pins are caught after release.
  always_ff @(posedge i_clk or negedge i_rstn)
  begin
    if (!i_rstn)
    begin
      meta <= '0;
      stable <= '0;
    end
    else
    begin
      meta <= p.raw;
      stable <= meta;
    end
  end

  assign p.clean = stable;
endmodule : pin_sync

// [design/cpu_state_power_mode_ctrl.sv]
// Purpose: Processing-state sequencer: reset, exceptions, bus release, power-down.
// Assumes: Memory port answers each request with a one-cycle ack; CPU core loads PC/SP.
// Notes: Standby stops the oscillator, so the settling count runs once it restarts.
//
// Added by the designer: the plain strobed port and the placing of the registers.
`timescale 1ns/1ns
module cpu_state_power_mode_ctrl #(
  parameter int OSC_STAB_CYCLES = cpu_state_pkg::OSC_STAB_CYCLES
) (
  input wire logic I_CORE_CLK,
  input wire logic I_RSTN,
  input wire logic I_RES_N,
  input wire logic I_NMI,
  input wire logic I_BUS_REQ,
  input wire logic [2:0] I_MODE_SEL,
  input wire logic I_SLEEP_EXEC,
  input wire logic I_EXC_REQ,
  input wire logic I_EXC_IRQ,
  input wire logic [7:0] I_EXC_VEC,
  input wire logic [3:0] I_EXC_LEVEL,
  input wire logic [31:0] I_CPU_PC,
  input wire logic [31:0] I_CPU_SP,
  input wire logic [31:0] I_CPU_SR,
  input wire logic I_MEM_ACK,
  input wire logic [31:0] I_MEM_RDATA,
  input wire logic [7:0] I_ADDR,
  input wire logic [31:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [31:0] O_RD_DATA,
  output logic [2:0] O_STATE,
  output logic O_CPU_HALT,
  output logic O_STANDBY,
  output logic O_OSC_STOP,
  output logic O_PERIPH_RST_N,
  output logic O_BSC_PFC_RST_N,
  output logic O_BUS_GRANT,
  output logic O_MEM_REQ,
  output logic O_MEM_WE,
  output logic [31:0] O_MEM_ADDR,
  output logic [31:0] O_MEM_WDATA,
  output logic O_EXC_ACK,
  output logic O_CPU_LOAD,
  output logic [31:0] O_NEW_PC,
  output logic [31:0] O_NEW_SP,
  output logic [3:0] O_INT_MASK,
  output logic [31:0] O_VBR,
  output logic O_AREA0_16BIT,
  output logic O_AREA0_ROM,
  output logic O_PROM_MODE
);
  localparam int STAB_W = $clog2(OSC_STAB_CYCLES + 1);

  cpu_state_pkg::cpu_state_t state;
  cpu_state_pkg::cpu_state_t next_state;
  cpu_state_pkg::exc_step_t step;
  logic res_n_s;
  logic nmi_s;
  logic bus_req_s;
  logic [2:0] mode_s;
  logic nmi_prev;
  logic nmi_rise;
  logic por_kind;
  logic standby_sel;
  logic standby;
  logic stab_wait;
  logic [STAB_W-1:0] stab_cnt;
  logic wake_sleep;
  logic [2:0] mode_reg;
  logic exc_is_reset;
  logic exc_is_irq;
  logic [7:0] exc_vec;
  logic [3:0] exc_level;
  logic [31:0] sp_lat;
  logic [31:0] pc_lat;
  logic [31:0] sr_lat;
  logic [31:0] step_addr;
  logic vbr_clr;
  logic [31:0] rd_word;

  if (OSC_STAB_CYCLES < 1)
  begin : g_bad_stab
    $error("OSC_STAB_CYCLES must be at least one");
  end

  // All pin levels come through the synchroniser before any logic reads them.
  pin_sync_if #(.W(6)) pins ();
  assign pins.raw = {I_RES_N, I_NMI, I_BUS_REQ, I_MODE_SEL};
  pin_sync #(.W(6)) u_pin_sync (
    .i_clk(I_CORE_CLK),
    .i_rstn(I_RSTN),
    .p(pins.sync_end)
  );
  assign res_n_s = pins.clean[5];
  assign nmi_s = pins.clean[4];
  assign bus_req_s = pins.clean[3];
  assign mode_s = pins.clean[2:0];
  assign nmi_rise = nmi_s && !nmi_prev;
  assign wake_sleep = I_EXC_REQ && (I_EXC_IRQ || (I_EXC_VEC == cpu_state_pkg::DMA_ADDR_ERR_VEC));

  // Next processing state; the reset pin overrides every other cause.
  always_comb
  begin
    next_state = state;
    case (state)
      cpu_state_pkg::ST_RESET: next_state = cpu_state_pkg::ST_EXC;
      cpu_state_pkg::ST_EXC:
        if (step == cpu_state_pkg::X_LOAD)
          next_state = cpu_state_pkg::ST_EXEC;
      // Exceptions first, then bus requests, then SLEEP, all at instruction boundaries.
      cpu_state_pkg::ST_EXEC:
        if (I_EXC_REQ)
          next_state = cpu_state_pkg::ST_EXC;
        else if (bus_req_s)
          next_state = cpu_state_pkg::ST_BUSREL;
        else if (I_SLEEP_EXEC)
          next_state = cpu_state_pkg::ST_PDOWN;
      cpu_state_pkg::ST_BUSREL:
        if (!bus_req_s)
          next_state = cpu_state_pkg::ST_EXEC;
      cpu_state_pkg::ST_PDOWN:
        if (standby ? (stab_wait && stab_cnt == STAB_W'(0)) : wake_sleep)
          next_state = cpu_state_pkg::ST_EXC;
      default: next_state = cpu_state_pkg::ST_RESET;
    endcase
    if (!res_n_s)
      next_state = cpu_state_pkg::ST_RESET;
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      state <= cpu_state_pkg::ST_RESET;
    else
      state <= next_state;
  end

  // Reset kind and mode pins caught while the reset pin is low; reset outputs follow it every cycle.
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      por_kind <= 1'b1;
      nmi_prev <= 1'b0;
      mode_reg <= cpu_state_pkg::MODE_AREA0_8BIT;
      O_PERIPH_RST_N <= 1'b0;
      O_BSC_PFC_RST_N <= 1'b0;
    end
    else
    begin
      nmi_prev <= nmi_s;
      if (!res_n_s)
      begin
        por_kind <= nmi_s;
        mode_reg <= mode_s;
      end
      O_PERIPH_RST_N <= res_n_s;
      O_BSC_PFC_RST_N <= res_n_s || !nmi_s;
    end
  end

  always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      O_AREA0_16BIT <= 1'b0;
      O_AREA0_ROM <= 1'b0;
      O_PROM_MODE <= 1'b0;
    end
    else
    begin
      O_AREA0_16BIT <= (mode_reg == cpu_state_pkg::MODE_AREA0_16BIT);
      O_AREA0_ROM <= (mode_reg == cpu_state_pkg::MODE_AREA0_ROM);
      O_PROM_MODE <= (mode_reg == cpu_state_pkg::MODE_PROM);
    end
  end

  // Power-down mode choice and oscillator settling count.
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      standby <= 1'b0;
      stab_wait <= 1'b0;
      stab_cnt <= '0;
    end
    else if (state != cpu_state_pkg::ST_PDOWN)
    begin
      standby <= standby_sel;
      stab_wait <= 1'b0;
      stab_cnt <= '0;
    end
    else if (standby && !stab_wait && nmi_rise)
    begin
      stab_wait <= 1'b1;
      stab_cnt <= STAB_W'(OSC_STAB_CYCLES - 1);
    end
    else if (stab_wait && stab_cnt != STAB_W'(0))
      stab_cnt <= stab_cnt - STAB_W'(1);
  end

  // Address of the current exception step.
  always_comb
  begin
    case (step)
      cpu_state_pkg::X_PUSH_SR: step_addr = sp_lat - cpu_state_pkg::STACK_WORD;
      cpu_state_pkg::X_PUSH_PC: step_addr = sp_lat - (cpu_state_pkg::STACK_WORD << 1);
      cpu_state_pkg::X_RD_VEC: step_addr = O_VBR + {22'h000000, exc_vec, 2'h0};
      cpu_state_pkg::X_RD_PC:
        step_addr = por_kind ? cpu_state_pkg::POR_PC_ADDR : cpu_state_pkg::MAN_PC_ADDR;
      cpu_state_pkg::X_RD_SP:
        step_addr = por_kind ? cpu_state_pkg::POR_SP_ADDR : cpu_state_pkg::MAN_SP_ADDR;
      default: step_addr = 32'h0000_0000;
    endcase
  end

  assign vbr_clr = (state == cpu_state_pkg::ST_EXC) && (step == cpu_state_pkg::X_RD_SP)
    && O_MEM_REQ && I_MEM_ACK;

  // Exception sequencer: latches the cause, runs the memory steps, loads the core.
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      step <= cpu_state_pkg::X_RD_PC;
      exc_is_reset <= 1'b1;
      exc_is_irq <= 1'b0;
      exc_vec <= 8'h00;
      exc_level <= 4'h0;
      sp_lat <= 32'h0000_0000;
      pc_lat <= 32'h0000_0000;
      sr_lat <= 32'h0000_0000;
      O_MEM_REQ <= 1'b0;
      O_MEM_WE <= 1'b0;
      O_MEM_ADDR <= 32'h0000_0000;
      O_MEM_WDATA <= 32'h0000_0000;
      O_EXC_ACK <= 1'b0;
      O_CPU_LOAD <= 1'b0;
      O_NEW_PC <= 32'h0000_0000;
      O_NEW_SP <= 32'h0000_0000;
      O_INT_MASK <= cpu_state_pkg::MASK_RESET;
    end
    else
    begin
      O_EXC_ACK <= 1'b0;
      O_CPU_LOAD <= (state == cpu_state_pkg::ST_EXC) && (step == cpu_state_pkg::X_LOAD);
      if (state == cpu_state_pkg::ST_RESET)
      begin
        step <= cpu_state_pkg::X_RD_PC;
        exc_is_reset <= 1'b1;
        O_MEM_REQ <= 1'b0;
        O_MEM_WE <= 1'b0;
        O_INT_MASK <= cpu_state_pkg::MASK_RESET;
      end
      else if (state != cpu_state_pkg::ST_EXC && next_state == cpu_state_pkg::ST_EXC)
      begin
        step <= cpu_state_pkg::X_PUSH_SR;
        exc_is_reset <= 1'b0;
        sp_lat <= I_CPU_SP;
        pc_lat <= I_CPU_PC;
        sr_lat <= I_CPU_SR;
        if (state == cpu_state_pkg::ST_PDOWN && standby)
        begin
          exc_is_irq <= 1'b1;
          exc_vec <= cpu_state_pkg::NMI_VEC;
          exc_level <= cpu_state_pkg::NMI_LEVEL;
        end
        else
        begin
          exc_is_irq <= I_EXC_IRQ;
          exc_vec <= I_EXC_VEC;
          exc_level <= I_EXC_LEVEL;
          O_EXC_ACK <= 1'b1;
        end
      end
      else if (state == cpu_state_pkg::ST_EXC)
      begin
        if (!O_MEM_REQ && step != cpu_state_pkg::X_LOAD)
        begin
          O_MEM_REQ <= 1'b1;
          O_MEM_WE <= (step == cpu_state_pkg::X_PUSH_SR) || (step == cpu_state_pkg::X_PUSH_PC);
          O_MEM_ADDR <= step_addr;
          O_MEM_WDATA <= (step == cpu_state_pkg::X_PUSH_SR) ? sr_lat : pc_lat;
        end
        else if (O_MEM_REQ && I_MEM_ACK)
        begin
          O_MEM_REQ <= 1'b0;
          O_MEM_WE <= 1'b0;
          case (step)
            cpu_state_pkg::X_PUSH_SR: step <= cpu_state_pkg::X_PUSH_PC;
            cpu_state_pkg::X_PUSH_PC:
            begin
              O_NEW_SP <= sp_lat - (cpu_state_pkg::STACK_WORD << 1);
              step <= cpu_state_pkg::X_RD_VEC;
            end
            cpu_state_pkg::X_RD_VEC:
            begin
              O_NEW_PC <= I_MEM_RDATA;
              if (exc_is_irq)
                O_INT_MASK <= exc_level;
              step <= cpu_state_pkg::X_LOAD;
            end
            cpu_state_pkg::X_RD_PC:
            begin
              O_NEW_PC <= I_MEM_RDATA;
              step <= cpu_state_pkg::X_RD_SP;
            end
            cpu_state_pkg::X_RD_SP:
            begin
              O_NEW_SP <= I_MEM_RDATA;
              O_INT_MASK <= cpu_state_pkg::MASK_RESET;
              step <= cpu_state_pkg::X_LOAD;
            end
            default: step <= cpu_state_pkg::X_LOAD;
          endcase
        end
      end
    end
  end

  // Registers reached by software; both reset kinds return them to defaults.
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      standby_sel <= 1'b0;
      O_VBR <= cpu_state_pkg::VBR_RESET;
    end
    else if (state == cpu_state_pkg::ST_RESET)
      standby_sel <= 1'b0;
    else if (vbr_clr)
      O_VBR <= cpu_state_pkg::VBR_RESET;
    else if (I_WR && I_ADDR == cpu_state_pkg::STANDBY_CTRL_ADDR)
      standby_sel <= I_WDATA[cpu_state_pkg::STANDBY_BIT_POS];
    else if (I_WR && I_ADDR == cpu_state_pkg::VECTOR_BASE_ADDR)
      O_VBR <= I_WDATA;
  end

  // Read word selection; unmapped addresses read as zero.
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (I_ADDR)
      cpu_state_pkg::STANDBY_CTRL_ADDR: rd_word[cpu_state_pkg::STANDBY_BIT_POS] = standby_sel;
      cpu_state_pkg::VECTOR_BASE_ADDR: rd_word = O_VBR;
      cpu_state_pkg::STATUS_ADDR:
      begin
        rd_word[cpu_state_pkg::STAT_STATE_LSB +: 3] = state;
        rd_word[cpu_state_pkg::STAT_MASK_LSB +: 4] = O_INT_MASK;
        rd_word[cpu_state_pkg::STAT_MODE_LSB +: 3] = mode_reg;
        rd_word[cpu_state_pkg::STAT_POR_BIT] = por_kind;
        rd_word[cpu_state_pkg::STAT_STBY_BIT] = standby;
      end
      default: rd_word = 32'h0000_0000;
    endcase
  end

  // Read data appear only in the cycle after the strobe.
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
      O_RD_DATA <= 32'h0000_0000;
    else
      O_RD_DATA <= I_RD ? rd_word : 32'h0000_0000;
  end

  // State-derived outputs except O_OSC_STOP are registered from the next state so they align with O_STATE.
  always_ff @(posedge I_CORE_CLK or negedge I_RSTN)
  begin
    if (!I_RSTN)
    begin
      O_STATE <= cpu_state_pkg::ST_RESET;
      O_CPU_HALT <= 1'b0;
      O_STANDBY <= 1'b0;
      O_OSC_STOP <= 1'b0;
      O_BUS_GRANT <= 1'b0;
    end
    else
    begin
      O_STATE <= next_state;
      O_CPU_HALT <= (next_state == cpu_state_pkg::ST_PDOWN);
      O_STANDBY <= (next_state == cpu_state_pkg::ST_PDOWN) && (state == cpu_state_pkg::ST_PDOWN
        ? standby : standby_sel);
      O_OSC_STOP <= (state == cpu_state_pkg::ST_PDOWN) && standby && !stab_wait && !nmi_rise
        && res_n_s;
      O_BUS_GRANT <= (next_state == cpu_state_pkg::ST_BUSREL);
    end
  end

  default clocking cb @(posedge I_CORE_CLK); endclocking
  default disable iff (!I_RSTN);

  sequence reset_fetch_s;
    (state == cpu_state_pkg::ST_EXC) && (step == cpu_state_pkg::X_RD_PC) && O_MEM_REQ;
  endsequence
  sequence push_sr_done_s;
    (step == cpu_state_pkg::X_PUSH_SR) && O_MEM_REQ && I_MEM_ACK;
  endsequence

  state_legal_a: assert property (state inside {cpu_state_pkg::ST_RESET, cpu_state_pkg::ST_EXC,
    cpu_state_pkg::ST_BUSREL, cpu_state_pkg::ST_EXEC, cpu_state_pkg::ST_PDOWN})
    else $error("state outside the five processing states");
  reset_hold_a: assert property (!res_n_s |=> state == cpu_state_pkg::ST_RESET)
    else $error("reset pin low but not in reset");
  por_ctrl_reset_a: assert property (!res_n_s && nmi_s |=> !O_BSC_PFC_RST_N)
    else $error("power-on reset did not reset bus controllers");
  manual_spare_a: assert property (!res_n_s && !nmi_s |=> O_BSC_PFC_RST_N)
    else $error("manual reset disturbed bus controllers");
  reset_vector_a: assert property (reset_fetch_s |-> O_MEM_ADDR == (por_kind ?
    cpu_state_pkg::POR_PC_ADDR : cpu_state_pkg::MAN_PC_ADDR) && !O_MEM_WE)
    else $error("reset vector read from wrong address");
  reset_load_a: assert property ($rose(O_CPU_LOAD) && exc_is_reset |->
    O_VBR == cpu_state_pkg::VBR_RESET && O_INT_MASK == cpu_state_pkg::MASK_RESET
    && state == cpu_state_pkg::ST_EXEC)
    else $error("reset exit did not clear base and set mask");
  push_order_a: assert property (push_sr_done_s |=> ##1 O_MEM_REQ && O_MEM_WE
    && O_MEM_ADDR == sp_lat - (cpu_state_pkg::STACK_WORD << 1) && O_MEM_WDATA == pc_lat)
    else $error("PC not pushed below SR");
  sleep_mode_a: assert property ($rose(state == cpu_state_pkg::ST_PDOWN) |->
    standby == $past(standby_sel) && O_CPU_HALT)
    else $error("power-down mode does not match standby bit");
  sleep_wake_a: assert property (state == cpu_state_pkg::ST_PDOWN && !standby && res_n_s
    && wake_sleep |=> state == cpu_state_pkg::ST_EXC)
    else $error("sleep did not wake on interrupt");
  standby_hold_a: assert property (state == cpu_state_pkg::ST_PDOWN && standby && res_n_s
    && (!stab_wait || stab_cnt != STAB_W'(0)) |=> state == cpu_state_pkg::ST_PDOWN)
    else $error("standby left before oscillator settled");
  bus_release_a: assert property (state == cpu_state_pkg::ST_BUSREL |-> !O_MEM_REQ
    && O_BUS_GRANT)
    else $error("own bus access during bus release");
  mode_decode_a: assert property (state == cpu_state_pkg::ST_EXEC |->
    O_AREA0_16BIT == (mode_reg == cpu_state_pkg::MODE_AREA0_16BIT)
    && O_PROM_MODE == (mode_reg == cpu_state_pkg::MODE_PROM))
    else $error("mode decode wrong");
  irq_mask_a: assert property ($rose(O_CPU_LOAD) && exc_is_irq && !exc_is_reset |->
    O_INT_MASK == exc_level)
    else $error("accepted level not written to mask");
endmodule : cpu_state_power_mode_ctrl

// [tb/mem_partner.sv]
// Purpose: Memory model that answers the sequencer's vector and stack accesses.
// Assumes: One request at a time, held until the one-cycle acknowledge.
// Notes: Read data is a fixed function of the address; i_dly sets the wait.
`timescale 1ns/1ns
module mem_partner (
  input wire logic i_clk,
  input wire logic i_req,
  input wire logic [31:0] i_addr,
  input wire logic [3:0] i_dly,
  output logic o_ack,
  output logic [31:0] o_rdata
);
  int wait_cnt;
  initial
  begin
    o_ack = 1'b0;
    o_rdata = 32'h0000_0000;
    wait_cnt = 0;
  end
  // Outside the ack cycle the data lines toggle, so stale data is never read as good.
  always @(posedge i_clk)
  begin
    if (i_req && !o_ack && wait_cnt >= i_dly)
    begin
      o_ack <= 1'b1;
      o_rdata <= {i_addr[15:0], 16'h5A3C};
      wait_cnt <= 0;
    end
    else
    begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      wait_cnt <= (i_req && !o_ack) ? wait_cnt + 1 : 0;
    end
  end
endmodule : mem_partner

// [tb/tb_top.sv]
// Purpose: Self-checking bench for the processing-state sequencer.
// Assumes: Settling count shortened to 8 cycles.
// Notes: Each scenario is one task that drives the pins and judges the outputs.
`timescale 1ns/1ns
module tb_top;
  logic clk, rstn, res_n, nmi, breq, slp, ereq, eirq, wr, rd, ack, mreq, mwe, eack, load;
  logic halt, stby, oscs, prst_n, bprst_n, grant, a16, arom, prom;
  logic [2:0] msel, state;
  logic [3:0] elvl, imask, dly;
  logic [7:0] evec, addr;
  logic [31:0] pc, sp, sr, rdat, wdat, rdd, maddr, mwd, npc, nsp, vector_base_reg, vb, d;
  logic [31:0] wq_a[$];
  logic [31:0] wq_d[$];
  logic [2:0] modes[4] = '{3'h1, 3'h2, 3'h7, 3'h0};
  int mismatches, checked, cycles;
  cpu_state_power_mode_ctrl #(.OSC_STAB_CYCLES(8)) dut (
    .I_CORE_CLK(clk), .I_RSTN(rstn), .I_RES_N(res_n), .I_NMI(nmi), .I_BUS_REQ(breq),
    .I_MODE_SEL(msel), .I_SLEEP_EXEC(slp), .I_EXC_REQ(ereq), .I_EXC_IRQ(eirq),
    .I_EXC_VEC(evec), .I_EXC_LEVEL(elvl), .I_CPU_PC(pc), .I_CPU_SP(sp), .I_CPU_SR(sr),
    .I_MEM_ACK(ack), .I_MEM_RDATA(rdat), .I_ADDR(addr), .I_WDATA(wdat), .I_WR(wr),
    .I_RD(rd), .O_RD_DATA(rdd), .O_STATE(state), .O_CPU_HALT(halt), .O_STANDBY(stby),
    .O_OSC_STOP(oscs), .O_PERIPH_RST_N(prst_n), .O_BSC_PFC_RST_N(bprst_n),
    .O_BUS_GRANT(grant), .O_MEM_REQ(mreq), .O_MEM_WE(mwe), .O_MEM_ADDR(maddr),
    .O_MEM_WDATA(mwd), .O_EXC_ACK(eack), .O_CPU_LOAD(load), .O_NEW_PC(npc),
    .O_NEW_SP(nsp), .O_INT_MASK(imask), .O_VBR(vector_base_reg), .O_AREA0_16BIT(a16),
    .O_AREA0_ROM(arom), .O_PROM_MODE(prom));
  mem_partner mem (.i_clk(clk), .i_req(mreq), .i_addr(maddr), .i_dly(dly), .o_ack(ack),
    .o_rdata(rdat));
  // Free-running core clock at 25 MHz.
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Log completed stack writes for the push-order checks.
  always @(posedge clk)
  begin
    cycles++;
    if (mreq === 1'b1 && ack === 1'b1 && mwe === 1'b1)
    begin
      wq_a.push_back(maddr);
      wq_d.push_back(mwd);
    end
    if (cycles > 5000)
    begin
      mismatches++;
      give_verdict();
    end
  end
  task automatic give_verdict();
    $display("Checks %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : give_verdict
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Vector memory contents, as the memory model serves them.
  function automatic logic [31:0] mw(input logic [31:0] a);
    return {a[15:0], 16'h5A3C};
  endfunction : mw
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wait_load();
    for (int i = 0; i < 80 && load !== 1'b1; i++) cyc(1);
    chk("load", 1, load);
  endtask : wait_load
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    addr <= a;
    wdat <= v;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : reg_wr
  task automatic reg_rd(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    d = rdd;
  endtask : reg_rd
  // Mode pins change only while the reset pin is low.
  task automatic do_reset(input logic n, input logic [2:0] m);
    @(posedge clk);
    res_n <= 1'b0;
    nmi <= n;
    msel <= m;
    // Reset pin stays low past the shortened settling time, as a standby exit needs.
    cyc(8);
    chk("prst_n", 0, prst_n);
    chk("bprst_n", !n, bprst_n);
    chk("reset_state", 0, state);
    @(posedge clk);
    res_n <= 1'b1;
    wait_load();
    chk("pc", mw(n ? 32'h0 : 32'h8), npc);
    chk("sp", mw(n ? 32'h4 : 32'hC), nsp);
    chk("vbr", 0, vector_base_reg);
    chk("mask", 32'hF, imask);
    chk("prst_up", 1, prst_n);
    chk("bprst_up", 1, bprst_n);
    chk("a16", m == 3'h1, a16);
    chk("rom", m == 3'h2, arom);
    chk("prom", m == 3'h7, prom);
    cyc(1);
    chk("exec", 3, state);
    vb = 32'h0;
  endtask : do_reset
  task automatic do_exc(input logic irq, input logic [7:0] v, input logic [3:0] lv,
    input logic [3:0] em);
    wq_a.delete();
    wq_d.delete();
    @(posedge clk);
    pc <= {v, 24'h00_1234};
    sp <= {16'h0000, v, 8'h80};
    sr <= {28'h0, lv};
    ereq <= 1'b1;
    eirq <= irq;
    evec <= v;
    elvl <= lv;
    for (int i = 0; i < 40 && eack !== 1'b1; i++) cyc(1);
    chk("ack", 1, eack);
    @(posedge clk);
    ereq <= 1'b0;
    wait_load();
    chk("sr_addr", {16'h0000, v, 8'h7C}, wq_a[0]);
    chk("sr_data", {28'h0, lv}, wq_d[0]);
    chk("pc_addr", {16'h0000, v, 8'h78}, wq_a[1]);
    chk("pc_data", {v, 24'h00_1234}, wq_d[1]);
    chk("new_sp", {16'h0000, v, 8'h78}, nsp);
    chk("handler", mw(vb + {22'h0, v, 2'b00}), npc);
    chk("mask", em, imask);
  endtask : do_exc
  task automatic sleep_now(input logic sb);
    reg_wr(8'h00, {31'h0, sb});
    @(posedge clk);
    slp <= 1'b1;
    @(posedge clk);
    slp <= 1'b0;
    cyc(1);
    chk("pdown", 4, state);
    chk("halt", 1, halt);
    chk("standby", sb, stby);
    chk("osc_stop", sb, oscs);
  endtask : sleep_now
  task automatic standby_wake();
    int i;
    // NMI must be low before standby so that its rise is a real wake event.
    @(posedge clk);
    nmi <= 1'b0;
    sleep_now(1'b1);
    @(posedge clk);
    nmi <= 1'b1;
    for (i = 0; i < 60 && state === 3'h4; i++) cyc(1);
    chk("settled", 1, i >= 8);
    wait_load();
    chk("nmi_pc", mw(vb + 32'h2C), npc);
    chk("nmi_mask", 32'hF, imask);
  endtask : standby_wake
  task automatic bus_rel();
    @(posedge clk);
    breq <= 1'b1;
    for (int i = 0; i < 20 && grant !== 1'b1; i++) cyc(1);
    chk("busrel", 2, state);
    chk("no_req", 0, mreq);
    @(posedge clk);
    breq <= 1'b0;
    cyc(6);
    chk("back", 3, state);
  endtask : bus_rel
  // Main sequence: power-on reset first, as required at power-up.
  initial
  begin
    {rstn, breq, slp, ereq, eirq, wr, rd} = '0;
    {res_n, nmi, dly, msel, evec, elvl, addr, pc, sp, sr, wdat} = '0;
    nmi = 1'b1;
    dly = 4'h2;
    repeat (6) @(posedge clk);
    rstn <= 1'b1;
    do_reset(1'b1, 3'h0);
    reg_wr(8'h04, 32'h100);
    vb = 32'h100;
    reg_rd(8'h1C);
    chk("unmapped", 0, d);
    reg_rd(8'h04);
    chk("vbr_rd", 32'h100, d);
    do_exc(1'b1, 8'h40, 4'h5, 4'h5);
    dly = 4'h0;
    do_exc(1'b0, 8'h09, 4'h2, 4'h5);
    sleep_now(1'b0);
    do_exc(1'b1, 8'h41, 4'h3, 4'h3);
    sleep_now(1'b0);
    do_exc(1'b0, 8'h0A, 4'h7, 4'h3);
    standby_wake();
    bus_rel();
    sleep_now(1'b1);
    foreach (modes[k]) do_reset(k % 2 == 0, modes[k]);
    give_verdict();
  end
endmodule : tb_top
